// [hdl/ssrb_pkg.sv]
// shared constants and types for the serial shadowed register bank
package ssrb_pkg;

  // serial frame geometry
  localparam int          INSTR_BITS   = 16;            // instruction length in bits
  localparam int          BYTE_BITS    = 8;             // data unit length in bits
  localparam int          ADDR_BITS    = 13;            // address field of the instruction
  localparam int          RW_POS       = 15;            // read flag position in instruction
  localparam int          LEN_HI_POS   = 14;            // length_bit_high position
  localparam int          LEN_LO_POS   = 13;            // length_bit_low position
  localparam logic [1:0]  LEN_STREAM   = 2'h3;          // both length bits set
  localparam logic [3:0]  INSTR_LAST   = 4'hf;          // last instruction bit count
  localparam logic [3:0]  BYTE_LAST    = 4'h7;          // last data bit count

  // register offsets
  localparam logic [12:0] ADDR_PORT_CFG   = 13'h0000;   // port configuration, unbuffered
  localparam logic [12:0] ADDR_CHIP_ID    = 13'h0001;   // identity, read only
  localparam logic [12:0] ADDR_GRADE      = 13'h0002;   // grade, unbuffered
  localparam logic [12:0] ADDR_INDEX_HI   = 13'h0004;   // channel index e..h, unbuffered
  localparam logic [12:0] ADDR_INDEX_LO   = 13'h0005;   // channel index a..d, unbuffered
  localparam logic [12:0] ADDR_FUNC_FIRST = 13'h0008;   // first buffered function register
  localparam logic [12:0] ADDR_FUNC_LAST  = 13'h002d;   // last buffered function register
  localparam logic [12:0] ADDR_CLOCK      = 13'h0009;   // converter_clock_setup
  localparam logic [12:0] ADDR_XFER       = 13'h00ff;   // shadow_update_trigger
  localparam int          FUNC_COUNT      = 38;         // buffered registers 0x08..0x2d

  // values after reset
  localparam logic [7:0]  PORT_CFG_RST = 8'h18;
  localparam logic [7:0]  GRADE_RST    = 8'h00;
  localparam logic [7:0]  INDEX_RST    = 8'h0f;
  localparam logic [7:0]  CLOCK_RST    = 8'h01;
  localparam logic [7:0]  FUNC_RST     = 8'h00;
  localparam logic [7:0]  XFER_RST     = 8'h00;

  // field positions
  localparam int          LSB_FIRST_HI  = 6;            // mirrored lsb-first bits
  localparam int          LSB_FIRST_LO  = 1;
  localparam logic [7:0]  GRADE_MASK    = 8'h30;        // only the grade field is stored
  localparam logic [7:0]  INDEX_MASK    = 8'h3f;        // undefined index bits read zero
  localparam int          SHADOW_BIT    = 0;            // shadow_update_bit
  localparam int          STAB_BIT      = 0;            // duty cycle stabiliser enable

  // serial engine phases
  typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_IDLE} ssrb_phase_e;

  // reset value of a buffered register by its index from ADDR_FUNC_FIRST
  function automatic logic [7:0] ssrb_func_default(input int idx);
    return (idx == int'(ADDR_CLOCK - ADDR_FUNC_FIRST)) ? CLOCK_RST : FUNC_RST;
  endfunction

endpackage

// [hdl/ssrb_wr_if.sv]
// write port shared by the bank and its buffered register stages
`timescale 1ns/1ps
`default_nettype none
interface ssrb_wr_if;
  logic        wrEn;    // one-cycle write strobe
  logic [12:0] wrAddr;  // target address
  logic [7:0]  wrData;  // byte written
  logic        xfer;    // shadow-to-active copy strobe

  modport bank  (output wrEn, output wrAddr, output wrData, output xfer);
  modport stage (input wrEn, input wrAddr, input wrData, input xfer);
endinterface
`default_nettype wire

// [hdl/ssrb_sync2.sv]
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ssrb_sync2 (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic metaQ;  // first stage, read only by the second

  // first stage may go metastable; only syncOut leaves the module
  always_ff @(posedge clk) begin
    if (srst) begin
      metaQ   <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      metaQ   <= asyncIn;
      syncOut <= metaQ;
    end
  end
endmodule
`default_nettype wire

// [hdl/ssrb_reg_stage.sv]
// one double-buffered register: shadow stage plus active stage
`timescale 1ns/1ps
`default_nettype none
module ssrb_reg_stage #(
  parameter logic [12:0] ADDR      = 13'h0000,
  parameter logic [7:0]  RESET_VAL = 8'h00
) (
  input  wire logic clk,
  input  wire logic srst,
  ssrb_wr_if.stage  wr,
  output logic [7:0] activeQ
);
  logic [7:0] shadowQ;  // value written but not yet applied
  wire        hit = wr.wrEn && (wr.wrAddr == ADDR);

  // a write lands only in the shadow stage
  always_ff @(posedge clk) begin
    if (srst) begin
      shadowQ <= RESET_VAL;
    end else if (hit) begin
      shadowQ <= wr.wrData;
    end
  end

  // the transfer strobe moves shadow to active
  always_ff @(posedge clk) begin
    if (srst) begin
      activeQ <= RESET_VAL;
    end else if (wr.xfer) begin
      activeQ <= shadowQ;
    end
  end
endmodule
`default_nettype wire

// [hdl/ssrb_top.sv]
// serial register bank: three-wire port on the serial clock, registers on clk
`timescale 1ns/1ps
`default_nettype none
module ssrb_top
  import ssrb_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5a  // arbitrary identity value
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    serialClk,
  input  wire logic                    port_select_n,
  input  wire logic                    sdioIn,
  output logic                         sdioOut,
  output logic                         sdioOe,
  output logic                         stabiliserEn,
  output logic                         lsbFirst,
  output logic [7:0]                   channelEnable,
  output logic [1:0]                   clockChanEnable,
  output logic [FUNC_COUNT*8-1:0]      funcActive
);

  //////////////////////////////////////////////////////////////////////////////
  // register bank state, clk domain

  logic [7:0]  portCfgQ;                // port configuration
  logic [7:0]  gradeQ;                  // grade field
  logic [7:0]  indexHiQ;                // channel enables e..h
  logic [7:0]  indexLoQ;                // channel and clock-lane enables
  logic        xferQ;                   // transfer bit, visible for one cycle
  logic [7:0]  funcAct [FUNC_COUNT];    // active stage of buffered registers

  ssrb_wr_if wrBus ();                  // write strobes towards the stages

  //////////////////////////////////////////////////////////////////////////////
  // serial engine state, serialClk domain

  ssrb_phase_e phaseQ;                  // instruction, data or ignore rest
  logic [3:0]  bitCntQ;                 // bit within instruction or byte
  logic [14:0] shiftQ;                  // bits received so far
  logic        isReadQ;                 // frame is a readback
  logic [1:0]  lenQ;                    // length bits of the instruction
  logic [1:0]  byteCntQ;                // bytes finished in this frame
  logic [12:0] addrQ;                   // address of the current byte
  logic        wrTogQ;                  // flips once per written byte
  logic [12:0] wrAddrQ;                 // address of the last written byte
  logic [7:0]  wrDataQ;                 // data of the last written byte
  logic        outQ;                    // data bit driven on the pin
  logic        oeQ;                     // pin driven by the device

  //////////////////////////////////////////////////////////////////////////////
  // decode of the serial stream

  wire [15:0] rawInstr   = {shiftQ, sdioIn};                      // first bit at msb
  wire [15:0] revInstr   = {<<{rawInstr}};
  wire [15:0] instrWord  = lsbFirst ? revInstr : rawInstr;
  wire [7:0]  rawByte    = {shiftQ[6:0], sdioIn};
  wire [7:0]  revByte    = {<<{rawByte}};
  wire [7:0]  byteIn     = lsbFirst ? revByte : rawByte;
  wire        instrDone  = (phaseQ == PH_INSTR) && (bitCntQ == INSTR_LAST);
  wire        byteDone   = (phaseQ == PH_DATA) && (bitCntQ == BYTE_LAST);
  wire        streaming  = (lenQ == LEN_STREAM);
  wire        lastByte   = !streaming && (byteCntQ == lenQ);
  // streaming walks down in msb-first order and up in lsb-first order
  wire [12:0] addrStep   = lsbFirst ? 13'h0001 : 13'h1fff;
  wire [12:0] addrNext   = addrQ + addrStep;

  //////////////////////////////////////////////////////////////////////////////
  // readback image; reads return the active stage of buffered registers

  wire        inFunc     = (addrQ >= ADDR_FUNC_FIRST) && (addrQ <= ADDR_FUNC_LAST);
  wire [5:0]  funcIdx    = 6'(addrQ - ADDR_FUNC_FIRST);
  logic [7:0] readByte;                 // byte selected by the current address

  // unmapped addresses read as zero
  always_comb begin
    readByte = 8'h00;
    if (inFunc) begin
      readByte = funcAct[funcIdx];
    end else begin
      case (addrQ)
        ADDR_PORT_CFG: readByte = portCfgQ;
        ADDR_CHIP_ID:  readByte = CHIP_ID;
        ADDR_GRADE:    readByte = gradeQ;
        ADDR_INDEX_HI: readByte = indexHiQ;
        ADDR_INDEX_LO: readByte = indexLoQ;
        ADDR_XFER:     readByte = {7'h00, xferQ};
        default:       readByte = 8'h00;
      endcase
    end
  end

  wire [2:0]  readIdx   = lsbFirst ? bitCntQ[2:0] : 3'(BYTE_LAST - bitCntQ);
  wire        readBit   = readByte[readIdx];
  wire        readDrive = (phaseQ == PH_DATA) && isReadQ;

  //////////////////////////////////////////////////////////////////////////////
  // serial engine; select high clears all but the written-byte hold at once, even without clock edges

  // phase and bit counter
  always_ff @(posedge serialClk or posedge port_select_n) begin
    if (port_select_n) begin
      phaseQ  <= PH_INSTR;
      bitCntQ <= 4'h0;
    end else begin
      case (phaseQ)
        PH_INSTR: begin
          bitCntQ <= instrDone ? 4'h0 : bitCntQ + 4'h1;
          if (instrDone) begin
            phaseQ <= PH_DATA;
          end
        end
        PH_DATA: begin
          bitCntQ <= byteDone ? 4'h0 : bitCntQ + 4'h1;
          if (byteDone && lastByte) begin
            phaseQ <= PH_IDLE;  // further clocks are ignored
          end
        end
        PH_IDLE: bitCntQ <= 4'h0;
        default: phaseQ  <= PH_INSTR;
      endcase
    end
  end

  // shift register, sampled on the rising edge
  always_ff @(posedge serialClk or posedge port_select_n) begin
    if (port_select_n) begin
      shiftQ <= 15'h0000;
    end else begin
      shiftQ <= rawInstr[14:0];
    end
  end

  // instruction fields and byte count
  always_ff @(posedge serialClk or posedge port_select_n) begin
    if (port_select_n) begin
      isReadQ  <= 1'b0;
      lenQ     <= 2'h0;
      byteCntQ <= 2'h0;
    end else if (instrDone) begin
      isReadQ  <= instrWord[RW_POS];
      lenQ     <= {instrWord[LEN_HI_POS], instrWord[LEN_LO_POS]};
      byteCntQ <= 2'h0;
    end else if (byteDone) begin
      byteCntQ <= byteCntQ + 2'h1;  // wraps harmlessly when streaming
    end
  end

  // address, stepped after each byte
  always_ff @(posedge serialClk or posedge port_select_n) begin
    if (port_select_n) begin
      addrQ <= 13'h0000;
    end else if (instrDone) begin
      addrQ <= instrWord[ADDR_BITS-1:0];
    end else if (byteDone) begin
      addrQ <= addrNext;
    end
  end

  // written byte held for the crossing; kept across select so none is lost
  always_ff @(posedge serialClk or posedge srst) begin
    if (srst) begin
      wrTogQ  <= 1'b0;
      wrAddrQ <= 13'h0000;
      wrDataQ <= 8'h00;
    end else if (byteDone && !isReadQ && !port_select_n) begin
      wrTogQ  <= ~wrTogQ;
      wrAddrQ <= addrQ;
      wrDataQ <= byteIn;
    end
  end

  // pin driver changes on the falling edge, half a bit ahead of sampling
  always_ff @(negedge serialClk or posedge port_select_n) begin
    if (port_select_n) begin
      oeQ  <= 1'b0;
      outQ <= 1'b0;
    end else begin
      oeQ  <= readDrive;
      outQ <= readDrive & readBit;
    end
  end

  assign sdioOut = outQ;
  assign sdioOe  = oeQ;

  //////////////////////////////////////////////////////////////////////////////
  // crossing into clk: toggle synchronised, address and data quasi-static

  logic togSync;                        // toggle after two flops
  logic togPrevQ;                       // toggle seen last cycle

  ssrb_sync2 u_togSync (
    .clk     (clk),
    .srst    (srst),
    .asyncIn (wrTogQ),
    .syncOut (togSync)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      togPrevQ <= 1'b0;
    end else begin
      togPrevQ <= togSync;
    end
  end

  // the held word is stable for eight serial clocks, far beyond the sync delay
  wire        wrPulse   = togSync ^ togPrevQ;
  wire        xferWrite = wrPulse && (wrAddrQ == ADDR_XFER) && wrDataQ[SHADOW_BIT];

  assign wrBus.wrEn   = wrPulse;
  assign wrBus.wrAddr = wrAddrQ;
  assign wrBus.wrData = wrDataQ;
  assign wrBus.xfer   = xferWrite;

  //////////////////////////////////////////////////////////////////////////////
  // unbuffered registers, applied as soon as the byte arrives

  wire hitCfg   = wrPulse && (wrAddrQ == ADDR_PORT_CFG);
  wire hitGrade = wrPulse && (wrAddrQ == ADDR_GRADE);
  wire hitIdxHi = wrPulse && (wrAddrQ == ADDR_INDEX_HI);
  wire hitIdxLo = wrPulse && (wrAddrQ == ADDR_INDEX_LO);

  // configuration; the whole byte is kept, lsbFirst decodes the mirrored bits
  always_ff @(posedge clk) begin
    if (srst) begin
      portCfgQ <= PORT_CFG_RST;
    end else if (hitCfg) begin
      portCfgQ <= wrDataQ;
    end
  end

  // grade and channel index registers
  always_ff @(posedge clk) begin
    if (srst) begin
      gradeQ   <= GRADE_RST;
      indexHiQ <= INDEX_RST;
      indexLoQ <= INDEX_RST;
    end else begin
      if (hitGrade) gradeQ   <= wrDataQ & GRADE_MASK;
      if (hitIdxHi) indexHiQ <= wrDataQ & INDEX_MASK;
      if (hitIdxLo) indexLoQ <= wrDataQ & INDEX_MASK;
    end
  end

  // transfer bit self-clears one cycle after the copy
  always_ff @(posedge clk) begin
    if (srst) begin
      xferQ <= XFER_RST[SHADOW_BIT];  // only the flag bit is stored
    end else begin
      xferQ <= xferWrite;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // buffered function registers 0x08..0x2d

  genvar gi;
  generate
    for (gi = 0; gi < FUNC_COUNT; gi++) begin : gFunc
      ssrb_reg_stage #(
        .ADDR      (ADDR_FUNC_FIRST + 13'(gi)),
        .RESET_VAL (ssrb_func_default(gi))
      ) u_stage (
        .clk     (clk),
        .srst    (srst),
        .wr      (wrBus),
        .activeQ (funcAct[gi])
      );
      assign funcActive[gi*8 +: 8] = funcAct[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // outputs to the converter

  wire [5:0] clockIdx = 6'(ADDR_CLOCK - ADDR_FUNC_FIRST);

  // lsb-first needs either mirrored bit, so a swapped nibble still works
  assign lsbFirst        = portCfgQ[LSB_FIRST_HI] | portCfgQ[LSB_FIRST_LO];
  assign stabiliserEn    = funcAct[clockIdx][STAB_BIT];
  assign channelEnable   = {indexHiQ[3:0], indexLoQ[3:0]};
  assign clockChanEnable = indexLoQ[5:4];

endmodule
`default_nettype wire

// [verif/ssrb_top_sva.sv]
// port-level checks for the serial register bank
`timescale 1ns/1ps
`default_nettype none
module ssrb_top_sva
  import ssrb_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    srst,
  input wire logic                    serialClk,
  input wire logic                    port_select_n,
  input wire logic                    sdioIn,
  input wire logic                    sdioOut,
  input wire logic                    sdioOe,
  input wire logic                    stabiliserEn,
  input wire logic                    lsbFirst,
  input wire logic [7:0]              channelEnable,
  input wire logic [1:0]              clockChanEnable,
  input wire logic [FUNC_COUNT*8-1:0] funcActive
);
  // buffered bank after reset: only the clock byte is set
  localparam logic [FUNC_COUNT*8-1:0] FUNC_DEF = {{(FUNC_COUNT-2)*8{1'b0}}, 16'h0100};
  logic [7:0]  bitCntQ;  // rising edges taken in this frame
  logic [15:0] insShQ;   // instruction in wire order
  logic [15:0] insRev;   // wire order reversed
  logic [15:0] ins;      // instruction as laid out
  logic [7:0]  fByte;    // active byte a read should return
  logic        expBit;   // level expected on the pin
  ////////////////////////////////////////////////////////////////////////
  // select high clears the count, just as it restarts the engine
  always_ff @(posedge serialClk or posedge port_select_n) begin
    if (port_select_n) begin
      bitCntQ <= 8'h00;
      insShQ  <= 16'h0000;
    end else begin
      if (bitCntQ != 8'hff) bitCntQ <= bitCntQ + 8'h01;  // saturate, streams are long
      if (bitCntQ < 8'h10) insShQ <= {insShQ[14:0], sdioIn};
    end
  end
  assign insRev = {<<{insShQ}};
  assign ins    = lsbFirst ? insRev : insShQ;
  assign fByte  = funcActive[8*(ins[5:0]-6'h08) +: 8];
  assign expBit = fByte[lsbFirst ? bitCntQ[2:0] : 3'h7 - bitCntQ[2:0]];
  ////////////////////////////////////////////////////////////////////////
  AST_OE_DESEL: assert property (@(posedge clk) disable iff (srst)
    port_select_n |-> !sdioOe && !sdioOut) else $error("pin driven while deselected");
  AST_RST_STAB: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> stabiliserEn) else $error("stabiliser off after reset");
  AST_RST_DEF: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> !lsbFirst && channelEnable == 8'hff && clockChanEnable == 2'h0)
    else $error("port defaults wrong after reset");
  AST_RST_FUNC: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> funcActive == FUNC_DEF) else $error("bank defaults wrong after reset");
  AST_NO_OE_INSTR: assert property (@(posedge serialClk) disable iff (port_select_n)
    bitCntQ < 8'h10 |-> !sdioOe) else $error("pin driven in instruction");
  AST_OE_READ: assert property (@(posedge serialClk) disable iff (port_select_n)
    bitCntQ >= 8'h10 && bitCntQ < 8'h18 |-> sdioOe == ins[15])
    else $error("pin direction wrong in first byte");
  AST_LEN_OE: assert property (@(posedge serialClk) disable iff (port_select_n)
    ins[14:13] != LEN_STREAM && bitCntQ >= 8'h18 + {3'h0, ins[14:13], 3'h0} |-> !sdioOe)
    else $error("pin driven past byte count");
  AST_STREAM_OE: assert property (@(posedge serialClk) disable iff (port_select_n)
    ins[15] && ins[14:13] == LEN_STREAM && bitCntQ >= 8'h10 |-> sdioOe)
    else $error("stream read stopped driving");
  AST_RD_DATA: assert property (@(posedge serialClk) disable iff (port_select_n)
    ins[15] && bitCntQ >= 8'h10 && bitCntQ < 8'h18 && ins[12:0] >= ADDR_FUNC_FIRST
    && ins[12:0] <= ADDR_FUNC_LAST |-> sdioOut == expBit) else $error("read bit wrong");
  // main scenarios
  CV_READ: cover property (@(posedge serialClk) ins[15] && bitCntQ == 8'h17);
  CV_STREAM: cover property (@(posedge serialClk) ins[14:13] == LEN_STREAM && bitCntQ == 8'h28);
  CV_LSB: cover property (@(posedge clk) $rose(lsbFirst));
endmodule
bind ssrb_top ssrb_top_sva ssrb_top_sva_i (
  .clk, .srst, .serialClk, .port_select_n, .sdioIn, .sdioOut, .sdioOe,
  .stabiliserEn, .lsbFirst, .channelEnable, .clockChanEnable, .funcActive
);
`default_nettype wire

// [verif/ssrb_host_model.sv]
// behavioural serial host framing instructions and bytes
`timescale 1ns/1ps
`default_nettype none
module ssrb_host_model (
  output logic      serialClk,
  output logic      port_select_n,
  output wire logic sdioIn,
  input  wire logic sdioOut,
  input  wire logic sdioOe
);
  logic hostBit;  // level the host puts on the pin
  logic hostOe;   // host drives the pin
  logic lsb;      // bit order in use, set by the bench
  // released pin shows the inverse of the last level, never a stale copy
  assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostBit : ~hostBit);
  // select rises after time zero, so its edge really clears the serial engine
  initial begin
    serialClk     = 1'b0;  // stands still between frames
    port_select_n = 1'b0;
    hostBit       = 1'b0;
    hostOe        = 1'b1;
    lsb           = 1'b0;
    #24 port_select_n = 1'b1;
  end
  // one frame: bytes packed from the top, select dropped after cut bits
  task automatic frame(input logic [15:0] ins, input logic [31:0] wd, input int nb,
                       input int cut, output logic [31:0] rd);
    int n;
    int p;
    rd = 32'h0;
    n = (cut < 16 + 8 * nb) ? cut : 16 + 8 * nb;
    port_select_n = 1'b0;
    #24;
    for (int i = 0; i < n; i++) begin
      p = 24 - 8 * ((i - 16) / 8) + (lsb ? i % 8 : 7 - i % 8);
      hostBit = (i < 16) ? ins[lsb ? i : 15 - i] : wd[p];
      hostOe = !(ins[15] && i >= 16);
      #24 serialClk = 1'b1;
      if (i >= 16) rd[p] = sdioIn;
      #24 serialClk = 1'b0;
    end
    #24 port_select_n = 1'b1;
    hostOe = 1'b1;
    #96;
  endtask
endmodule
`default_nettype wire

// [verif/ssrb_top_tb.sv]
// self-checking bench for the serial register bank
`timescale 1ns/1ps
`default_nettype none
module ssrb_top_tb
  import ssrb_pkg::*;
;
  localparam logic [7:0] CHIP_ID = 8'h3c;  // arbitrary identity value
  logic                    clk;              // bank clock
  logic                    srst;             // bank reset
  wire logic               serialClk;        // link clock from host
  wire logic               port_select_n;    // select, active low
  wire logic               sdioIn;           // resolved data pin
  logic                    sdioOut;
  logic                    sdioOe;
  logic                    stabiliserEn;
  logic                    lsbFirst;
  logic [7:0]              channelEnable;
  logic [1:0]              clockChanEnable;
  logic [FUNC_COUNT*8-1:0] funcActive;
  logic [31:0]             rdv;              // bytes of the last frame
  int                      mismatches;
  int                      num_checks;
  // reset image across the map, unmapped 0x30 reads zero
  logic [7:0] defA [10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h08, 8'h09, 8'h2d, 8'hff, 8'h30};
  logic [7:0] defV [10] = '{8'h18, CHIP_ID, 8'h00, 8'h0f, 8'h0f,
                            8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  ////////////////////////////////////////////////////////////////////////
  ssrb_top #(.CHIP_ID(CHIP_ID)) ssrb_top_i (
    .clk, .srst, .serialClk, .port_select_n, .sdioIn, .sdioOut, .sdioOe,
    .stabiliserEn, .lsbFirst, .channelEnable, .clockChanEnable, .funcActive
  );
  ssrb_host_model ssrb_host_model_i (.serialClk, .port_select_n, .sdioIn, .sdioOut, .sdioOe);
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // a frame, then time for the crossing and the register update
  task automatic fr(input logic [15:0] ins, input logic [31:0] wd, input int nb, input int cut);
    ssrb_host_model_i.frame(ins, wd, nb, cut, rdv);
    repeat (8) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    fr({8'h00, a}, {d, 24'h0}, 1, 99);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    fr({8'h80, a}, 32'h0, 1, 99);
    chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, rdv[31:24]});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    srst = 1'b0;
    // a real rising edge, so the async serial-side holding flops clear
    #0 srst = 1'b1;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    foreach (defA[i]) rdc(defA[i], defV[i]);
    chk("chan", 32'hff, {24'h0, channelEnable});
    // shadow holds until the transfer bit is written
    wr(8'h09, 8'h00);
    rdc(8'h09, 8'h01);
    chk("stab", 32'h1, {31'h0, stabiliserEn});
    wr(8'hff, 8'h01);
    chk("stab", 32'h0, {31'h0, stabiliserEn});
    rdc(8'h09, 8'h00);
    rdc(8'hff, 8'h00);
    // unbuffered places act at once
    wr(8'h05, 8'h33);
    chk("chan", 32'hf3, {24'h0, channelEnable});
    chk("clkch", 32'h3, {30'h0, clockChanEnable});
    wr(8'h02, 8'h10);
    rdc(8'h02, 8'h10);
    // stream, over-long counted frame, and a cut frame
    fr(16'h600c, 32'ha1b2c300, 3, 99);
    fr(16'h200e, 32'hd1d2d300, 3, 99);
    fr(16'h0010, 32'h5a000000, 1, 20);
    wr(8'h11, 8'h5c);
    chk("f0c", 32'h0, {24'h0, funcActive[8*4 +: 8]});
    wr(8'hff, 8'h01);
    fr(16'he00e, 32'h0, 4, 99);
    chk("strm", 32'hd1d2a1b2, rdv);
    chk("f0a", 32'hc3, {24'h0, funcActive[8*2 +: 8]});
    rdc(8'h10, 8'h00);
    rdc(8'h11, 8'h5c);
    // switch to lsb-first order, mirrored nibbles
    wr(8'h00, 8'h42);
    chk("lsb", 32'h1, {31'h0, lsbFirst});
    ssrb_host_model_i.lsb = 1'b1;
    wr(8'h12, 8'h83);
    wr(8'hff, 8'h01);
    rdc(8'h12, 8'h83);
    chk("f12", 32'h83, {24'h0, funcActive[8*10 +: 8]});
    complete_run();
  end
  // all frames need well under this span
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
